// ### rtl/spdc_pkg.sv
// Package for the software power down controller.
// Assumes a single 50 MHz clock domain and an 8-bit special register port.
package spdc_pkg;

  // ********************************************************************
  // Register offsets and field positions
  // ********************************************************************
  localparam logic [7:0] SPDC_ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] SPDC_ADDR_WAKE_CONTROL  = 8'h88;
  localparam logic [7:0] SPDC_ADDR_SYSTEM_CONTROL = 8'hB1;
  localparam logic [7:0] SPDC_ADDR_STATUS        = 8'hB2;
  localparam int SPDC_BIT_ARM        = 1;
  localparam int SPDC_BIT_START      = 6;
  localparam int SPDC_BIT_WAKE_EN    = 7;
  localparam int SPDC_BIT_WAKE_SEL   = 4;
  localparam int SPDC_BIT_MAP_SEL    = 4;
  localparam logic [7:0] SPDC_POWER_CONTROL_RESET = 8'h00;
  localparam logic [1:0] SPDC_WAKE_CONTROL_RESET  = 2'h0;
  localparam logic       SPDC_MAP_SEL_RESET       = 1'b0;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int SPDC_CLK_MHZ        = 50;
  localparam int SPDC_WAKE_LOW_US    = 10;
  localparam int SPDC_WAKE_LOW_CYC   = SPDC_WAKE_LOW_US * SPDC_CLK_MHZ;
  localparam int SPDC_OSC_STABLE_CYC = 64;
  localparam int SPDC_CALL_CYC       = 2;
  localparam logic [15:0] SPDC_WAKE_VECTOR = 16'h007B;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [2:0] {
    SPDC_RUN     = 3'h0,
    SPDC_DOWN    = 3'h1,
    SPDC_LATCH   = 3'h2,
    SPDC_STARTUP = 3'h3,
    SPDC_CALL    = 3'h4,
    SPDC_SERVICE = 3'h5
  } spdc_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } spdc_bus_t;

  typedef struct packed {
    logic osc_enable;
    logic core_halt;
    logic fetch_discard;
    logic periph_freeze;
    logic irq_global_off;
    logic take_wake_irq;
    logic port0_float;
    logic port2_addr;
    logic port_hold;
  } spdc_ctrl_t;

  typedef struct packed {
    spdc_state_t state;
    logic        arm;
    logic        wake_en;
    logic        wake_sel;
    logic        map_sel;
    logic [5:0]  power_control_reg_keep;
    logic [8:0]  low_cnt;
    logic [6:0]  osc_cnt;
    logic [1:0]  call_cnt;
    logic        ext_code_at_entry;
    logic        ale;
    logic        fetch_strobe;
    logic [7:0]  rdata;
    spdc_ctrl_t  ctrl;
    logic [1:0]  pin_int_sync;
    logic [1:0]  pin_can_sync;
  } spdc_regs_t;

endpackage : spdc_pkg

// ### rtl/spdc_top.sv
// Software power down controller: arming, entry, hold and wake-up exit.
// Assumes the core drives the register port and reports interrupt_return;
// the wake pins come from outside and are synchronised here.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module spdc_top (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire spdc_pkg::spdc_bus_t bus,
  output logic [7:0]            rdata,
  input  wire logic             external_interrupt_pin,
  input  wire logic             can_receive_pin,
  input  wire logic             ext_code,
  input  wire logic             osc_stable,
  input  wire logic             interrupt_return,
  input  wire logic             core_ale,
  input  wire logic             core_fetch_strobe,
  output logic                  ale,
  output logic                  program_fetch_strobe,
  output spdc_pkg::spdc_ctrl_t  ctrl
);

  // ********************************************************************
  // State registers
  // ********************************************************************
  spdc_pkg::spdc_regs_t r_reg;
  spdc_pkg::spdc_regs_t r_next;

  // Decodes a write to a given address.
  function automatic logic wr_hit(input spdc_pkg::spdc_bus_t b,
                                  input logic [7:0] a);
    wr_hit = b.wr && (b.addr == a);
  endfunction : wr_hit

  // ********************************************************************
  // Next-state logic
  // ********************************************************************
  // Computes the whole next state in one pass.
  always_comb begin
    logic wake_pin;
    logic power_control_reg_wr;
    logic st_bit;
    logic arm_bit;
    r_next = r_reg;
    r_next.pin_int_sync = {r_reg.pin_int_sync[0], external_interrupt_pin};
    r_next.pin_can_sync = {r_reg.pin_can_sync[0], can_receive_pin};
    wake_pin = r_reg.wake_sel ? r_reg.pin_can_sync[1]
                              : r_reg.pin_int_sync[1];
    power_control_reg_wr = wr_hit(bus, spdc_pkg::SPDC_ADDR_POWER_CONTROL);
    st_bit  = bus.wdata[spdc_pkg::SPDC_BIT_START];
    arm_bit = bus.wdata[spdc_pkg::SPDC_BIT_ARM];
    r_next.rdata = 8'h00;

    // Register writes are only honoured while the core runs.
    if (r_reg.state == spdc_pkg::SPDC_RUN) begin
      if (power_control_reg_wr) begin
        r_next.power_control_reg_keep = {bus.wdata[7], bus.wdata[5:2], bus.wdata[0]};
        // Arm alone arms; any other write drops the arm.
        r_next.arm = arm_bit && !st_bit;
      end
      if (wr_hit(bus, spdc_pkg::SPDC_ADDR_SYSTEM_CONTROL)) begin
        r_next.map_sel = bus.wdata[spdc_pkg::SPDC_BIT_MAP_SEL];
      end
      if (wr_hit(bus, spdc_pkg::SPDC_ADDR_WAKE_CONTROL) && r_reg.map_sel) begin
        r_next.wake_en  = bus.wdata[spdc_pkg::SPDC_BIT_WAKE_EN];
        r_next.wake_sel = bus.wdata[spdc_pkg::SPDC_BIT_WAKE_SEL];
      end
    end

    // Read data; arm and start bits always read as zero.
    if (bus.rd) begin
      unique case (bus.addr)
        spdc_pkg::SPDC_ADDR_POWER_CONTROL:
          r_next.rdata = {r_reg.power_control_reg_keep[5], 1'b0, r_reg.power_control_reg_keep[4:1],
                          1'b0, r_reg.power_control_reg_keep[0]};
        spdc_pkg::SPDC_ADDR_WAKE_CONTROL:
          r_next.rdata = r_reg.map_sel ?
            {r_reg.wake_en, 2'h0, r_reg.wake_sel, 4'h0} : 8'h00;
        spdc_pkg::SPDC_ADDR_SYSTEM_CONTROL:
          r_next.rdata = {3'h0, r_reg.map_sel, 4'h0};
        spdc_pkg::SPDC_ADDR_STATUS:
          r_next.rdata = {5'h00, r_reg.state};
        default:
          r_next.rdata = 8'h00;
      endcase
    end

    // Power down sequence.
    unique case (r_reg.state)
      spdc_pkg::SPDC_RUN: begin
        r_next.ale          = core_ale;
        r_next.fetch_strobe = core_fetch_strobe;
        r_next.ext_code_at_entry = ext_code;
        // Start after arm enters; the start write ends execution.
        if (power_control_reg_wr && st_bit && !arm_bit && r_reg.arm) begin
          r_next.state = spdc_pkg::SPDC_DOWN;
          r_next.arm   = 1'b0;
        end
      end
      spdc_pkg::SPDC_DOWN: begin
        r_next.low_cnt = 9'h000;
        // Only an enabled wake source leaves; else reset alone.
        if (r_reg.wake_en && !wake_pin) begin
          r_next.state = spdc_pkg::SPDC_LATCH;
        end
      end
      spdc_pkg::SPDC_LATCH: begin
        // Pin must stay low the full minimum time.
        if (wake_pin) begin
          r_next.state = spdc_pkg::SPDC_DOWN;
        end else if (r_reg.low_cnt ==
                     9'(spdc_pkg::SPDC_WAKE_LOW_CYC - 1)) begin
          r_next.state   = spdc_pkg::SPDC_STARTUP;
          r_next.osc_cnt = 7'h00;
        end else begin
          r_next.low_cnt = r_reg.low_cnt + 9'h001;
        end
      end
      spdc_pkg::SPDC_STARTUP: begin
        // Oscillator watchdog: wait for a stable nominal clock.
        if (osc_stable &&
            r_reg.osc_cnt == 7'(spdc_pkg::SPDC_OSC_STABLE_CYC - 1)) begin
          r_next.state    = spdc_pkg::SPDC_CALL;
          r_next.call_cnt = 2'h0;
        end else if (osc_stable) begin
          r_next.osc_cnt = r_reg.osc_cnt + 7'h01;
        end else begin
          r_next.osc_cnt = 7'h00;
        end
      end
      spdc_pkg::SPDC_CALL: begin
        // Two-cycle vector call; strobes follow the core again.
        r_next.ale          = core_ale;
        r_next.fetch_strobe = core_fetch_strobe;
        if (r_reg.call_cnt == 2'(spdc_pkg::SPDC_CALL_CYC - 1)) begin
          r_next.state = spdc_pkg::SPDC_SERVICE;
        end else begin
          r_next.call_cnt = r_reg.call_cnt + 2'h1;
        end
      end
      spdc_pkg::SPDC_SERVICE: begin
        r_next.ale          = core_ale;
        r_next.fetch_strobe = core_fetch_strobe;
        // Return resumes after the entry sequence.
        if (interrupt_return) begin
          r_next.state = spdc_pkg::SPDC_RUN;
        end
      end
      default: begin
        r_next.state = spdc_pkg::SPDC_RUN;
      end
    endcase

    // Strobes low from entry until the wake call.
    if (r_next.state == spdc_pkg::SPDC_DOWN ||
        r_next.state == spdc_pkg::SPDC_LATCH ||
        r_next.state == spdc_pkg::SPDC_STARTUP) begin
      r_next.ale          = 1'b0;
      r_next.fetch_strobe = 1'b0;
    end

    // Control outputs derived from the next state.
    r_next.ctrl.core_halt  = r_next.state == spdc_pkg::SPDC_DOWN ||
                             r_next.state == spdc_pkg::SPDC_LATCH ||
                             r_next.state == spdc_pkg::SPDC_STARTUP;
    r_next.ctrl.osc_enable = !(r_next.state == spdc_pkg::SPDC_DOWN ||
                               r_next.state == spdc_pkg::SPDC_LATCH);
    r_next.ctrl.port_hold  = r_next.ctrl.core_halt;
    r_next.ctrl.fetch_discard =
      r_next.state == spdc_pkg::SPDC_CALL;
    r_next.ctrl.take_wake_irq =
      r_reg.state == spdc_pkg::SPDC_STARTUP &&
      r_next.state == spdc_pkg::SPDC_CALL;
    r_next.ctrl.periph_freeze = r_next.state != spdc_pkg::SPDC_RUN;
    r_next.ctrl.irq_global_off =
      r_next.wake_en || r_next.state != spdc_pkg::SPDC_RUN;
    r_next.ctrl.port0_float = r_next.ext_code_at_entry;
    r_next.ctrl.port2_addr  = r_next.ext_code_at_entry &&
                              !r_next.ctrl.core_halt;
  end

  // ********************************************************************
  // State flip-flops
  // ********************************************************************
  // Reset returns all control registers to defaults and starts clocks.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.power_control_reg_keep <= spdc_pkg::SPDC_POWER_CONTROL_RESET[5:0];
      r_reg.wake_en   <= spdc_pkg::SPDC_WAKE_CONTROL_RESET[1];
      r_reg.wake_sel  <= spdc_pkg::SPDC_WAKE_CONTROL_RESET[0];
      r_reg.map_sel   <= spdc_pkg::SPDC_MAP_SEL_RESET;
      r_reg.ctrl.osc_enable <= 1'b1;
      r_reg.pin_int_sync <= 2'h3;
      r_reg.pin_can_sync <= 2'h3;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from flip-flops.
  assign rdata                = r_reg.rdata;
  assign ale                  = r_reg.ale;
  assign program_fetch_strobe = r_reg.fetch_strobe;
  assign ctrl                 = r_reg.ctrl;

endmodule : spdc_top

`default_nettype wire

// ### testbench/spdc_asserts.sv
// Port checker for the software power down controller.
// Assumes a bind onto spdc_top; one clock, sys_rst active high.
`timescale 1ns/1ps
`default_nettype none
module spdc_asserts (
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire spdc_pkg::spdc_bus_t  bus,
  input wire logic [7:0]           rdata,
  input wire logic                 ext_code,
  input wire logic                 ale,
  input wire logic                 program_fetch_strobe,
  input wire spdc_pkg::spdc_ctrl_t ctrl
);
  // ********************
  // Checks
  // ********************
  // Every check runs on clk and rests while reset is high.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  halt_latency_a: assert property (
    (bus.wr && bus.addr == 8'h87 && bus.wdata == 8'h02 && !ctrl.core_halt)
    ##1 (bus.wr && bus.addr == 8'h87 && bus.wdata == 8'h40)
    |=> ctrl.core_halt) else $error("No halt after start write.");
  both_bits_a: assert property (
    bus.wr && bus.addr == 8'h87 && bus.wdata[1] && bus.wdata[6] &&
    !ctrl.core_halt |=> !ctrl.core_halt) else $error("Combined write halted.");
  read_zero_a: assert property (
    bus.rd && bus.addr == 8'h87 |=> !rdata[1] && !rdata[6])
    else $error("Arm or start bit read as one.");
  entry_state_a: assert property (
    $rose(ctrl.core_halt) |-> !ctrl.osc_enable && ctrl.port_hold &&
    ctrl.port0_float == $past(ext_code) && !ctrl.port2_addr)
    else $error("Wrong outputs at entry.");
  pd_strobes_a: assert property (
    !ctrl.osc_enable |-> !ale && !program_fetch_strobe)
    else $error("Strobe high with clock stopped.");
  wake_call_a: assert property (
    ctrl.take_wake_irq |-> ctrl.osc_enable && ctrl.periph_freeze &&
    ctrl.irq_global_off ##1 !ctrl.take_wake_irq)
    else $error("Bad wake interrupt call.");
  discard_two_a: assert property (
    $rose(ctrl.fetch_discard) |-> ctrl.fetch_discard [*2]
    ##1 !ctrl.fetch_discard) else $error("Discard not two cycles.");
  reset_exit_a: assert property (
    $fell(sys_rst) |-> ctrl.osc_enable && !ctrl.core_halt)
    else $error("Reset exit left clock off.");
endmodule : spdc_asserts
bind spdc_top spdc_asserts u_chk (.clk(clk), .sys_rst(sys_rst), .bus(bus),
  .rdata(rdata), .ext_code(ext_code), .ale(ale),
  .program_fetch_strobe(program_fetch_strobe), .ctrl(ctrl));
`default_nettype wire

// ### testbench/spdc_wake_src.sv
// Wake pin model: drives the selected wake pin low for a set time.
// Assumes a one-cycle go pulse with sel and low_cyc already valid.
`timescale 1ns/1ps
`default_nettype none
module spdc_wake_src (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       sel,
  input  wire logic [9:0] low_cyc,
  output logic            pin_int,
  output logic            pin_can
);
  // ********************
  // Wake request
  // ********************
  logic [9:0] cnt_reg = 10'h000;
  // Loads the low time on go and counts it away.
  always_ff @(posedge clk) begin
    if (go) begin
      cnt_reg <= low_cyc;
    end else if (cnt_reg != 10'h000) begin
      cnt_reg <= cnt_reg - 10'h001;
    end
  end
  // Both pins rest high, as if pulled up, so the device stays down.
  assign pin_int = !(cnt_reg != 10'h000 && !sel);
  assign pin_can = !(cnt_reg != 10'h000 && sel);
endmodule : spdc_wake_src
`default_nettype wire

// ### testbench/spdc_top_tb.sv
// Bench for the power down controller: register port, wake pins, reset.
// Assumes the wake pin model; the core strobes are held high but for one low cycle.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR %0t: got %h exp %h", $time, a, b); end end
`define WAITC(c) for (int n = 0; n < 2000 && !(c); n++) begin \
  @(posedge clk); #1; end
module spdc_top_tb;
  logic                 clk = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 ext_code = 1'b0;
  logic                 osc_stable = 1'b0;
  logic                 int_ret = 1'b0;
  logic                 go = 1'b0;
  logic                 core_stb = 1'b1;
  logic                 sel = 1'b0;
  logic [9:0]           low_cyc = 10'h000;
  spdc_pkg::spdc_bus_t  bus = '0;
  logic [7:0]           rdata;
  logic                 pin_int;
  logic                 pin_can;
  logic                 ale;
  logic                 fetch_strobe;
  spdc_pkg::spdc_ctrl_t ctrl;
  int                   fail_count = 0;
  int                   num_checks = 0;
  // ********************
  // Harness
  // ********************
  // Free-running 50 MHz clock.
  always #10 clk = ~clk;
  spdc_top uut (.clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .external_interrupt_pin(pin_int), .can_receive_pin(pin_can),
    .ext_code(ext_code), .osc_stable(osc_stable), .interrupt_return(int_ret),
    .core_ale(core_stb), .core_fetch_strobe(core_stb), .ale(ale),
    .program_fetch_strobe(fetch_strobe), .ctrl(ctrl));
  spdc_wake_src peer (.clk(clk), .go(go), .sel(sel), .low_cyc(low_cyc),
    .pin_int(pin_int), .pin_can(pin_can));
  // One write cycle; the strobe stays up until the next call or idle.
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
  endtask : bus_wr
  // One read cycle; data are compared in the cycle after the strobe.
  task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : bus_rd
  task automatic idle;
    @(posedge clk) bus <= '0;
  endtask : idle
  // Asks the wake pin model for one low period on pin s.
  task automatic pulse(input logic s, input logic [9:0] n);
    @(posedge clk) go <= 1'b1;
    sel <= s;
    low_cyc <= n;
    @(posedge clk) go <= 1'b0;
  endtask : pulse
  // Arm then start in back-to-back writes; the core halts next cycle.
  task automatic enter;
    bus_wr(8'h87, 8'h02);
    bus_wr(8'h87, 8'h40);
    idle();
    #1 `CHK(ctrl.core_halt, 1'b1)
  endtask : enter
  // Full wake cycle through pin s, with a too short pulse first.
  task automatic wake(input logic s);
    @(posedge clk) ext_code <= s;
    bus_wr(8'hB1, 8'h10);
    bus_wr(8'h88, {1'b1, 2'b00, s, 4'h0});
    bus_rd(8'h88, {1'b1, 2'b00, s, 4'h0});
    bus_wr(8'hB1, 8'h00);
    enter();
    `CHK(ctrl.port0_float, s)
    pulse(s, 10'h064);
    repeat (200) @(posedge clk);
    #1 `CHK(ctrl.osc_enable, 1'b0)
    pulse(s, 10'h208);
    `WAITC(ctrl.osc_enable)
    `CHK(ctrl.osc_enable, 1'b1)
    `CHK(ale, 1'b0)
    @(posedge clk) osc_stable <= 1'b1;
    `WAITC(ctrl.take_wake_irq)
    `CHK(ctrl.take_wake_irq, 1'b1)
    `CHK(ctrl.irq_global_off, 1'b1)
    `CHK(ctrl.fetch_discard, 1'b1)
    // The return can only come once the two-cycle call is over.
    repeat (2) @(posedge clk);
    #1 `CHK(ctrl.fetch_discard, 1'b0)
    @(posedge clk) int_ret <= 1'b1;
    @(posedge clk) int_ret <= 1'b0;
    osc_stable <= 1'b0;
    bus_rd(8'hB2, 8'h00);
    `CHK(ctrl.periph_freeze, 1'b0)
    `CHK(ctrl.irq_global_off, 1'b1)
    `CHK(ctrl.port2_addr, s)
    bus_wr(8'hB1, 8'h10);
    bus_wr(8'h88, 8'h00);
    bus_wr(8'hB1, 8'h00);
    idle();
    #1 `CHK(ctrl.irq_global_off, 1'b0)
  endtask : wake
  // Prints the counts and the verdict, then stops the run.
  task automatic finish_test;
    $display("Checks %0d, errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  // Main sequence: refusals, reset exit, then both wake pins.
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1 `CHK(ctrl.osc_enable, 1'b1)
    bus_rd(8'h87, 8'h00);
    bus_wr(8'h87, 8'hFF);
    idle();
    #1 `CHK(ctrl.core_halt, 1'b0)
    bus_rd(8'h87, 8'hBD);
    bus_wr(8'h87, 8'h40);
    idle();
    #1 `CHK(ctrl.core_halt, 1'b0)
    bus_rd(8'h10, 8'h00);
    `CHK(ale, 1'b1)
    // One low cycle of the core strobes must pass through while running.
    @(posedge clk) core_stb <= 1'b0;
    @(posedge clk) core_stb <= 1'b1;
    #1 `CHK(ale, 1'b0)
    bus_wr(8'hB1, 8'h10);
    enter();
    `CHK(fetch_strobe, 1'b0)
    pulse(1'b0, 10'h258);
    repeat (700) @(posedge clk);
    #1 `CHK(ctrl.osc_enable, 1'b0)
    @(posedge clk) sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    bus_rd(8'h87, 8'h00);
    `CHK(ctrl.core_halt, 1'b0)
    `CHK(ctrl.osc_enable, 1'b1)
    bus_rd(8'hB1, 8'h00);
    wake(1'b0);
    wake(1'b1);
    finish_test();
  end
  // Cuts a hang short after well over the expected run time.
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end
endmodule : spdc_top_tb
`default_nettype wire
